// [rtl/iwd_decoder.sv]
`timescale 1ns/100ps
module iwd_decoder #(
  parameter int WORD_W = iwd_pkg::WORD_W
) (
  // clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        SRST_I,
  // instruction word from program memory
  input  wire logic [13:0] INSTR_WORD_I,
  // execution feedback for the current instruction
  input  wire logic        COND_TRUE_I,
  input  wire logic        PTR_CHANGE_I,
  // timing
  output logic [1:0]       PHASE_O,
  output logic             FETCH_O,
  output logic             IDLE_SLOT_O,
  // decoded fields
  output logic [1:0]       CLASS_O,
  output logic [5:0]       OPCODE_O,
  output logic [6:0]       FILE_ADDR_O,
  output logic             DEST_FILE_O,
  output logic [2:0]       BIT_SEL_O,
  output logic [7:0]       BIT_MASK_O,
  output logic [7:0]       LIT8_O,
  output logic [10:0]      LIT11_O,
  output logic             IS_CTL_XFER_O
);
  // refuse geometry that the fixed field split cannot serve
  if (WORD_W != 14)
  begin : g_bad_word
    $error("iwd_decoder serves 14-bit words only");
  end
  if (iwd_pkg::FILE_LSB + iwd_pkg::FILE_W != iwd_pkg::DEST_POS)
  begin : g_bad_dest
    $error("destination select must sit just above the file operand");
  end
  if (iwd_pkg::FILE_LSB + iwd_pkg::FILE_W != iwd_pkg::BITSEL_LSB)
  begin : g_bad_bitsel
    $error("bit select must sit just above the file operand");
  end
  if (iwd_pkg::BITSEL_W != 3)
  begin : g_bad_bitw
    $error("bit select must cover the eight bits of a register");
  end
  if (iwd_pkg::LIT_LSB + iwd_pkg::LIT11_W > iwd_pkg::GROUP_LSB)
  begin : g_bad_lit
    $error("long literal would overlap the group bits");
  end
  if (iwd_pkg::PHASES != 4)
  begin : g_bad_phase
    $error("an instruction cycle must span four clocks");
  end

  // one-hot mask for a bit number
  function automatic logic [7:0] bit_mask(input logic [2:0] n);
    bit_mask = 8'h01 << n;
  endfunction : bit_mask

  // true when the word belongs to the given group
  function automatic logic in_group(input logic [13:0]        w,
                                    input iwd_pkg::iwd_group_t g);
    in_group = (w[13:12] == g);
  endfunction : in_group

  // operation-select bits only; don't-care positions forced to 0
  function automatic logic [5:0] opcode_of(input logic [13:0] w);
    logic [1:0] g;
    g = w[13:12];
    case (g)
      iwd_pkg::IWD_GRP_BIT:
        opcode_of = {w[13:10], 2'h0};
      iwd_pkg::IWD_GRP_JMP:
        opcode_of = {w[13:11], 3'h0};
      iwd_pkg::IWD_GRP_LIT:
        if (!w[11])
          opcode_of = {w[13:10], 2'h0};
        else if (w[10:9] == 2'h3)
          opcode_of = {w[13:9], 1'h0};
        else
          opcode_of = w[13:8];
      default:
        opcode_of = w[13:8];
    endcase
  endfunction : opcode_of

  logic [1:0]  phase;
  logic        cycle_end;
  logic        idle_pend;
  logic        next_idle;
  logic [13:0] word;
  logic [13:0] next_word;
  logic [1:0]  grp;
  logic [1:0]  cls;
  logic [5:0]  opc;
  logic [2:0]  bsel;
  logic        is_byte;
  logic        is_bit;
  logic        is_jmp;
  logic [6:0]  next_file;
  logic        next_dest;
  logic [2:0]  next_bit_sel;
  logic [7:0]  next_bit_mask;
  logic [7:0]  next_lit8;
  logic [10:0] next_lit11;

  // four-phase instruction cycle
  iwd_phase_gen #(
    .PHASES (iwd_pkg::PHASES)
  ) u_phase (
    .clk_i       (REF_CLK_I),
    .srst_i      (SRST_I),
    .phase_o     (phase),
    .cycle_end_o (cycle_end)
  );

  // a true test or pointer change outside an idle slot turns the next cycle into an idle slot
  assign next_idle = cycle_end ? ((COND_TRUE_I | PTR_CHANGE_I) & ~idle_pend)
                               : idle_pend;
  // fetched word is replaced by an idle slot when flushed
  assign next_word = next_idle ? iwd_pkg::WORD_RST
                               : INSTR_WORD_I;

  // field split from the held word
  assign grp  = word[13:12];
  assign cls  = (grp == iwd_pkg::IWD_GRP_BYTE) ? iwd_pkg::IWD_CLS_BYTE :
                (grp == iwd_pkg::IWD_GRP_BIT)  ? iwd_pkg::IWD_CLS_BIT  :
                iwd_pkg::IWD_CLS_LCTL;
  // opcode keeps only bits that select the operation
  assign opc  = opcode_of(word);
  assign bsel = word[iwd_pkg::BITSEL_LSB +: iwd_pkg::BITSEL_W];

  // group strobes for the operand steering and the control-transfer flag
  assign is_byte = in_group(word, iwd_pkg::IWD_GRP_BYTE);
  assign is_bit  = in_group(word, iwd_pkg::IWD_GRP_BIT);
  assign is_jmp  = in_group(word, iwd_pkg::IWD_GRP_JMP);

  // operands; dest and bit fields are held at 0 outside their groups, file and literal fields pass through
  assign next_file     = word[iwd_pkg::FILE_LSB +: iwd_pkg::FILE_W];
  assign next_dest     = is_byte & word[iwd_pkg::DEST_POS];
  assign next_bit_sel  = is_bit ? bsel : 3'h0;
  assign next_bit_mask = is_bit ? bit_mask(bsel) : 8'h00;
  assign next_lit8     = word[iwd_pkg::LIT_LSB +: iwd_pkg::LIT8_W];
  assign next_lit11    = word[iwd_pkg::LIT_LSB +: iwd_pkg::LIT11_W];

  // instruction register, loaded at end of each instruction cycle
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      word      <= iwd_pkg::WORD_RST;
      idle_pend <= 1'b0;
    end
    else if (cycle_end)
    begin
      word      <= next_word;
      idle_pend <= next_idle;
    end
  end

  // registered timing outputs
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      PHASE_O     <= iwd_pkg::PHASE_RST;
      FETCH_O     <= 1'b0;
      IDLE_SLOT_O <= 1'b0;
    end
    else
    begin
      PHASE_O     <= phase;
      FETCH_O     <= cycle_end;
      IDLE_SLOT_O <= idle_pend;
    end
  end

  // registered group and opcode outputs
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      CLASS_O       <= iwd_pkg::IWD_CLS_BYTE;
      OPCODE_O      <= 6'h00;
      IS_CTL_XFER_O <= 1'b0;
    end
    else
    begin
      CLASS_O       <= cls;
      OPCODE_O      <= opc;
      IS_CTL_XFER_O <= is_jmp;
    end
  end

  // registered operand outputs
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      FILE_ADDR_O <= 7'h00;
      DEST_FILE_O <= 1'b0;
      BIT_SEL_O   <= 3'h0;
      BIT_MASK_O  <= 8'h00;
      LIT8_O      <= 8'h00;
      LIT11_O     <= 11'h000;
    end
    else
    begin
      FILE_ADDR_O <= next_file;
      DEST_FILE_O <= next_dest;
      BIT_SEL_O   <= next_bit_sel;
      BIT_MASK_O  <= next_bit_mask;
      LIT8_O      <= next_lit8;
      LIT11_O     <= next_lit11;
    end
  end
endmodule : iwd_decoder

// [rtl/iwd_pkg.sv]
package iwd_pkg;
  // word geometry
  localparam int WORD_W     = 14;
  localparam int FILE_W     = 7;
  localparam int BITSEL_W   = 3;
  localparam int LIT8_W     = 8;
  localparam int LIT11_W    = 11;
  // field positions
  localparam int FILE_LSB   = 0;
  localparam int DEST_POS   = 7;
  localparam int BITSEL_LSB = 7;
  localparam int LIT_LSB    = 0;
  localparam int GROUP_LSB  = 12;
  localparam int SUBOP_LSB  = 8;
  localparam int CTL_SEL    = 11;
  // oscillator periods per instruction cycle
  localparam int PHASES     = 4;
  localparam logic [1:0] PHASE_RST  = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  // reset value of the instruction register (an idle slot)
  localparam logic [13:0] WORD_RST  = 14'h0000;

  // instruction groups from the two top bits
  typedef enum logic [1:0]
  {
    IWD_GRP_BYTE = 2'b00,
    IWD_GRP_BIT  = 2'b01,
    IWD_GRP_JMP  = 2'b10,
    IWD_GRP_LIT  = 2'b11
  } iwd_group_t;

  // instruction classes reported outward
  typedef enum logic [1:0]
  {
    IWD_CLS_BYTE = 2'b00,
    IWD_CLS_BIT  = 2'b01,
    IWD_CLS_LCTL = 2'b10
  } iwd_class_t;
endpackage : iwd_pkg

// [rtl/iwd_phase_gen.sv]
`timescale 1ns/100ps
// four-phase sequencer: one instruction cycle per four clock periods
module iwd_phase_gen #(
  parameter int PHASES = iwd_pkg::PHASES
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // phase state
  output logic [1:0]      phase_o,
  output logic            cycle_end_o
);
  // refuse any other phase count at elaboration
  if (PHASES != 4)
  begin : g_bad_phases
    $error("iwd_phase_gen serves exactly four phases");
  end

  logic [1:0] next_phase;

  // wrap after the last phase
  assign next_phase  = (phase_o == iwd_pkg::PHASE_LAST) ?
                       iwd_pkg::PHASE_RST : phase_o + 2'h1;
  assign cycle_end_o = (phase_o == iwd_pkg::PHASE_LAST);

  // phase counter
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      phase_o <= iwd_pkg::PHASE_RST;
    else
      phase_o <= next_phase;
  end
endmodule : iwd_phase_gen

// [sim/iwd_decoder_asserts.sv]
`timescale 1ns/100ps
// decoder output checks
module iwd_decoder_asserts (
  input wire logic        REF_CLK_I,
  input wire logic        SRST_I,
  input wire logic [1:0]  PHASE_O,
  input wire logic        FETCH_O,
  input wire logic        IDLE_SLOT_O,
  input wire logic [1:0]  CLASS_O,
  input wire logic [5:0]  OPCODE_O,
  input wire logic [6:0]  FILE_ADDR_O,
  input wire logic        DEST_FILE_O,
  input wire logic [7:0]  BIT_MASK_O,
  input wire logic [2:0]  BIT_SEL_O,
  input wire logic [7:0]  LIT8_O,
  input wire logic [10:0] LIT11_O,
  input wire logic        IS_CTL_XFER_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);
  a_fetch_every_four: assert property
    (FETCH_O |=> !FETCH_O [*3] ##1 FETCH_O) else $error("fetch spacing");
  a_fetch_last_phase: assert property
    (FETCH_O |-> PHASE_O == 2'h3) else $error("fetch phase");
  a_fields_stand: assert property
    (!$past(FETCH_O) |-> $stable({CLASS_O, OPCODE_O, LIT11_O, IDLE_SLOT_O}))
    else $error("fields moved");
  a_idle_four_clk: assert property
    ($rose(IDLE_SLOT_O) |-> IDLE_SLOT_O [*4] ##1 !IDLE_SLOT_O)
    else $error("idle length");
  a_idle_all_zero: assert property
    (IDLE_SLOT_O |-> CLASS_O == 2'h0 && LIT11_O == 11'h0 && !DEST_FILE_O)
    else $error("idle not zero");
  a_dest_byte_only: assert property
    (DEST_FILE_O |-> CLASS_O == 2'h0 && LIT8_O[7]) else $error("dest");
  a_bit_mask_hot: assert property
    (BIT_MASK_O == (CLASS_O == 2'h1 ? 8'h01 << BIT_SEL_O : 8'h00))
    else $error("bit mask");
  a_ctl_in_class: assert property
    (CLASS_O != 2'h3 && (!IS_CTL_XFER_O || CLASS_O == 2'h2))
    else $error("class");
  a_operand_low_bits: assert property
    (FILE_ADDR_O == LIT11_O[6:0] && LIT8_O == LIT11_O[7:0])
    else $error("operand bits");
endmodule : iwd_decoder_asserts
bind iwd_decoder iwd_decoder_asserts iwd_decoder_asserts_inst (.*);

// [sim/iwd_prog_mem.sv]
`timescale 1ns/100ps
// program memory: next word after each fetch pulse
module iwd_prog_mem (
  input  wire logic   clk_i,
  input  wire logic   srst_i,
  input  wire logic   fetch_i,
  output logic [13:0] word_o
);
  logic [13:0] mem [16];
  logic [3:0]  ptr;
  // program has no direction_load_op words
  assign word_o = mem[ptr]; // whole word held
  always_ff @(posedge clk_i)
    ptr <= srst_i ? 4'h0 : ptr + {3'h0, fetch_i};
endmodule : iwd_prog_mem

// [sim/testbench.sv]
`timescale 1ns/100ps
`define CHK(a, b) \
  begin \
    samples_checked++; \
    if ((a) !== (b)) \
    begin \
      n_fail++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, a, b); \
    end \
  end
module testbench;
  logic REF_CLK_I = 1'b0, SRST_I = 1'b1, COND_TRUE_I = 1'b0;
  logic PTR_CHANGE_I = 1'b0, FETCH_O, IDLE_SLOT_O, DEST_FILE_O;
  logic IS_CTL_XFER_O;
  logic [13:0] INSTR_WORD_I;
  logic [1:0] PHASE_O, CLASS_O;
  logic [5:0] OPCODE_O;
  logic [6:0] FILE_ADDR_O;
  logic [2:0] BIT_SEL_O;
  logic [7:0] BIT_MASK_O, LIT8_O;
  logic [10:0] LIT11_O;
  int n_fail = 0;
  int samples_checked = 0;
  logic [13:0] prog [10] = '{14'h0705, 14'h07ff, 14'h1792, 14'h1803,
    14'h2abc, 14'h2f5a, 14'h3e81, 14'h3ca5, 14'h3000, 14'h3300};
  // feedback {test true, pointer changed} per word
  logic [1:0] fb [10] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h1, 2'h0, 2'h0,
    2'h0, 2'h0};
  always #25 REF_CLK_I = ~REF_CLK_I;
  iwd_prog_mem iwd_prog_mem_inst (.clk_i(REF_CLK_I), .srst_i(SRST_I),
    .fetch_i(FETCH_O), .word_o(INSTR_WORD_I));
  iwd_decoder iwd_decoder_inst (.*);
  task automatic tally_and_finish;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // run the program, checking each decoded cycle
  task automatic t_program;
    logic [13:0] w;
    logic [5:0] opc;
    logic idl;
    int n;
    idl = 1'b0;
    for (int k = 0; k < 10; k++)
    begin
      for (n = 0; n < 9 && FETCH_O !== 1'b1 || n == 0; n++)
        @(negedge REF_CLK_I);
      if (n == 9)
      begin
        n_fail++;
        tally_and_finish();
      end
      `CHK(PHASE_O, 2'h3)
      @(negedge REF_CLK_I);
      idl = k > 0 && fb[k - 1] != 2'h0 && !idl;
      w = idl ? 14'h0000 : prog[k];
      `CHK(IDLE_SLOT_O, idl)
      `CHK(CLASS_O, w[13] ? 2'h2 : {1'b0, w[12]})
      `CHK(FILE_ADDR_O, w[6:0])
      `CHK(DEST_FILE_O, w[13:12] == 2'h0 && w[7])
      `CHK(BIT_SEL_O, w[13:12] == 2'h1 ? w[9:7] : 3'h0)
      `CHK(LIT8_O, w[7:0])
      `CHK(LIT11_O, w[10:0])
      `CHK(IS_CTL_XFER_O, w[13:12] == 2'h2)
      `CHK(BIT_MASK_O, w[13:12] == 2'h1 ? 8'h01 << w[9:7] : 8'h00)
      `CHK(FETCH_O, 1'b0)
      if (k >= 8)
        `CHK(OPCODE_O, 6'h30)
      if (k == 9)
        `CHK(OPCODE_O, opc)
      opc = OPCODE_O;
      @(posedge REF_CLK_I);
      {COND_TRUE_I, PTR_CHANGE_I} <= fb[k];
    end
    $display("t_program done");
  endtask : t_program
  // load program, hold reset two clocks, run
  initial
  begin
    for (int i = 0; i < 16; i++)
      iwd_prog_mem_inst.mem[i] = i < 10 ? prog[i] : 14'h0000;
    repeat (2) @(posedge REF_CLK_I);
    SRST_I <= 1'b0;
    t_program();
    tally_and_finish();
  end
endmodule : testbench
